// [hpe_pkg.sv]
// package for the host port and error reporting block of the disc controller
// assumes a 16-bit register port decoded by the surrounding bus logic
package hpe_pkg;

    // register port ----
    localparam logic [15:0] init_word_mini  = 16'h00a8; // diagnostic, 16-bit host
    localparam logic [15:0] init_word_micro = 16'h00ac; // diagnostic, 32-bit host
    localparam logic [15:0] init_word_board = 16'h00b0; // diagnostic, on-board port
    localparam logic [15:0] step_base       = 16'h0800; // step response marker bit
    localparam logic [2:0]  step_last       = 3'h4;     // four host words, then done
    localparam logic [15:0] sa_idle_reset   = 16'h0000;

    // fatal codes ----
    localparam logic [15:0] fatal_ram       = 16'hab0b;
    localparam logic [15:0] fatal_rom       = 16'hac0b;
    localparam logic [15:0] fatal_cache     = 16'had0b;
    localparam logic [15:0] fatal_unlock    = 16'hae0b;
    localparam logic [15:0] fatal_get_msg   = 16'haf0b;
    localparam logic [15:0] fatal_clr_rings = 16'hb00b;
    localparam logic [15:0] fatal_free_buf  = 16'hb10b;
    localparam logic [15:0] fatal_q_unfork  = 16'hb20b;
    localparam logic [15:0] fatal_q_wait    = 16'hb30b;
    localparam logic [15:0] fatal_q_pause   = 16'hb40b;
    localparam logic [15:0] fatal_parity    = 16'hb60b;

    // error correction ----
    localparam int          ecc_poly_bits   = 48;
    localparam int          ecc_span_bits   = 11;
    localparam logic [3:0]  ecc_retry_max   = 4'ha;

    // timing: controller timeout for abort, in microseconds
    localparam int          abort_timeout_us = 1000;
    localparam int          clk_mhz          = 125;
    localparam int          abort_cycles     = abort_timeout_us * clk_mhz;

    // fault source index ----
    localparam int          n_faults        = 11;

    // command completion status
    typedef enum logic [3:0] {
        st_success      = 4'h0,
        st_aborted      = 4'h1,
        st_compare_err  = 4'h2,
        st_ctrl_err     = 4'h3,
        st_data_err     = 4'h4,
        st_host_buf_err = 4'h5,
        st_write_prot   = 4'h6,
        st_invalid      = 4'h7
    } cmd_status_t;

    // disc commands
    typedef enum logic [3:0] {
        op_access       = 4'h0,
        op_abort        = 4'h1,
        op_available    = 4'h2,
        op_compare      = 4'h3,
        op_erase        = 4'h4,
        op_get_cmd_st   = 4'h5,
        op_get_unit_st  = 4'h6,
        op_online       = 4'h7,
        op_read         = 4'h8,
        op_set_ctrl     = 4'h9,
        op_set_unit     = 4'ha,
        op_write        = 4'hb
    } opcode_t;

    // unit states
    typedef enum logic [1:0] {
        unit_offline    = 2'h0,
        unit_available  = 2'h1,
        unit_online     = 2'h3
    } unit_state_t;

    // command request from the command ring front end
    typedef struct packed {
        logic        valid;
        opcode_t     op;
        logic [7:0]  tag;
    } cmd_req_t;

    // events reported by the data path for the running command
    typedef struct packed {
        logic        done;
        logic        data_err;
        logic        correct_ok;
        logic        compare_miss;
        logic        bus_fault;
        logic        internal_err;
    } xfer_evt_t;

    // completion to the response ring front end
    typedef struct packed {
        logic        valid;
        logic [7:0]  tag;
        cmd_status_t status;
    } cmd_cpl_t;

    // initialization progress
    typedef enum logic [2:0] {
        in_idle   = 3'b000,
        in_step   = 3'b001,
        in_test   = 3'b011,
        in_run    = 3'b010,
        in_fatal  = 3'b110
    } init_state_t;

endpackage

// [hpe_fatal_enc.sv]
// priority encoder from fault sources to the fatal code shown to the host
// assumes fault lines are synchronous one-cycle or level flags on core_clk
`timescale 1ns/1ps
module hpe_fatal_enc
    import hpe_pkg::*;
(
    // fault sources
    input  wire logic [n_faults-1:0] fault,
    // encoded result
    output logic                     any,
    output logic [15:0]              code
);
    // lowest index wins; self-test faults sit first
    always_comb begin
        any  = |fault;
        code = sa_idle_reset;
        if (fault[0]) code = fatal_ram;
        else if (fault[1]) code = fatal_rom;
        else if (fault[2]) code = fatal_cache;
        else if (fault[3]) code = fatal_unlock;
        else if (fault[4]) code = fatal_get_msg;
        else if (fault[5]) code = fatal_clr_rings;
        else if (fault[6]) code = fatal_free_buf;
        else if (fault[7]) code = fatal_q_unfork;
        else if (fault[8]) code = fatal_q_wait;
        else if (fault[9]) code = fatal_q_pause;
        else if (fault[10]) code = fatal_parity;
    end
endmodule // hpe_fatal_enc

// [hpe_cmd_exec.sv]
// completion status logic for one running disc command
// assumes the data path reports events for the command it was handed
`timescale 1ns/1ps
module hpe_cmd_exec
    import hpe_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // command in
    input  wire cmd_req_t    req,
    input  wire logic        unit_wp,
    input  wire logic        abort_req,
    input  wire xfer_evt_t   evt,
    // state and completion out
    output logic             busy,
    output logic             retry,
    output logic             zero_fill,
    output unit_state_t      unit_state,
    output cmd_cpl_t         cpl
);
    logic        busy_ff, nxt_busy;
    opcode_t     op_ff, nxt_op;
    logic [7:0]  tag_ff, nxt_tag;
    logic [3:0]  retry_ff, nxt_retry;
    logic [$clog2(abort_cycles+1)-1:0] abt_ff, nxt_abt;
    logic        abt_on_ff, nxt_abt_on;
    unit_state_t unit_ff, nxt_unit;
    cmd_cpl_t    cpl_ff, nxt_cpl;

    // next state of the single command slot
    always_comb begin
        nxt_busy   = busy_ff;
        nxt_op     = op_ff;
        nxt_tag    = tag_ff;
        nxt_retry  = retry_ff;
        nxt_abt    = abt_ff;
        nxt_abt_on = abt_on_ff;
        nxt_unit   = unit_ff;
        nxt_cpl    = '0;
        if (!busy_ff && req.valid) begin
            nxt_tag = req.tag;
            nxt_op  = req.op;
            if ((req.op == op_write || req.op == op_erase) && unit_wp) begin
                nxt_cpl = '{1'b1, req.tag, st_write_prot};
            end else if (req.op == op_available) begin
                // online goes available; available stays put
                if (unit_ff == unit_online) nxt_unit = unit_available;
                nxt_cpl = '{1'b1, req.tag, st_success};
            end else if (req.op == op_online) begin
                nxt_unit = unit_online;
                nxt_cpl  = '{1'b1, req.tag, st_success};
            end else begin
                nxt_busy   = 1'b1;
                nxt_retry  = '0;
                nxt_abt_on = 1'b0;
                nxt_abt    = '0;
            end
        end else if (busy_ff) begin
            if (abort_req && !abt_on_ff) begin
                nxt_abt_on = 1'b1;
                nxt_abt    = '0;
            end else if (abt_on_ff) begin
                nxt_abt = abt_ff + 1'b1;
            end
            if (evt.bus_fault) begin
                nxt_cpl  = '{1'b1, tag_ff, st_host_buf_err};
                nxt_busy = 1'b0;
            end else if (evt.internal_err) begin
                // non-fatal: slot freed so later commands proceed
                nxt_cpl  = '{1'b1, tag_ff, st_ctrl_err};
                nxt_busy = 1'b0;
            end else if (evt.data_err) begin
                if (retry_ff < ecc_retry_max) begin
                    nxt_retry = retry_ff + 1'b1;
                end else if (!evt.correct_ok) begin
                    nxt_cpl  = '{1'b1, tag_ff, st_data_err};
                    nxt_busy = 1'b0;
                end
            end else if (evt.compare_miss && op_ff == op_compare) begin
                nxt_cpl  = '{1'b1, tag_ff, st_compare_err};
                nxt_busy = 1'b0;
            end else if (evt.done) begin
                nxt_cpl  = '{1'b1, tag_ff, st_success};
                nxt_busy = 1'b0;
            end else if (abt_on_ff && abt_ff >= ($bits(abt_ff))'(abort_cycles - 1)) begin
                nxt_cpl  = '{1'b1, tag_ff, st_aborted};
                nxt_busy = 1'b0;
            end
        end
    end

    // register the slot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_ff   <= 1'b0;
            op_ff     <= op_access;
            tag_ff    <= 8'h00;
            retry_ff  <= 4'h0;
            abt_ff    <= '0;
            abt_on_ff <= 1'b0;
            unit_ff   <= unit_offline;
            cpl_ff    <= '0;
        end else begin
            busy_ff   <= nxt_busy;
            op_ff     <= nxt_op;
            tag_ff    <= nxt_tag;
            retry_ff  <= nxt_retry;
            abt_ff    <= nxt_abt;
            abt_on_ff <= nxt_abt_on;
            unit_ff   <= nxt_unit;
            cpl_ff    <= nxt_cpl;
        end
    end

    assign busy       = busy_ff;
    assign retry      = busy_ff & evt.data_err & (retry_ff < ecc_retry_max);
    assign zero_fill  = busy_ff & (op_ff == op_erase);
    assign unit_state = unit_ff;
    assign cpl        = cpl_ff;
endmodule // hpe_cmd_exec

// [hpe_host_port.sv]
// host register port, initialization steps and fatal reporting
// assumes the bus logic gives one-cycle read and write strobes per register
`timescale 1ns/1ps
module hpe_host_port
    import hpe_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                bus_init,
    // init_and_poll register access
    input  wire logic                ip_rd,
    input  wire logic                ip_wr,
    input  wire logic [15:0]         ip_wdata,
    // status_and_address register access
    input  wire logic                sa_rd,
    input  wire logic                sa_wr,
    input  wire logic [15:0]         sa_wdata,
    output logic [15:0]              sa_rdata,
    // self test and fault sources
    input  wire logic                test_done,
    input  wire logic [n_faults-1:0] fault,
    // command path
    input  wire cmd_req_t            cmd_req,
    input  wire logic                unit_wp,
    input  wire logic                abort_req,
    input  wire xfer_evt_t           xfer_evt,
    output cmd_cpl_t                 cmd_cpl,
    output logic                     cmd_busy,
    output logic                     ecc_retry,
    output logic                     erase_zero_fill,
    output unit_state_t              unit_state,
    // controller side outputs
    output logic                     init_pulse,
    output logic                     poll_pulse,
    output logic                     diag_start,
    output logic [1:0]               diag_host,
    output logic [15:0]              host_param [0:3],
    output logic                     param_valid,
    output logic                     running,
    output logic                     fatal_led
);
    // ----
    // fatal code selection
    // ----
    logic        flt_any;
    logic [15:0] flt_code;

    hpe_fatal_enc u_enc (
        .fault (fault),
        .any   (flt_any),
        .code  (flt_code)
    );

    // ----
    // initialization state
    // ----
    init_state_t st_ff, nxt_st;
    logic [2:0]  step_ff, nxt_step;
    logic [15:0] sa_rd_ff, nxt_sa_rd;   // host-visible read register
    logic [15:0] sa_wr_ff, nxt_sa_wr;   // independent write register
    logic [15:0] prm_ff [0:3];
    logic [15:0] nxt_prm [0:3];
    logic        prm_ok_ff, nxt_prm_ok;
    logic        poll_ff, nxt_poll;
    logic        diag_ff, nxt_diag;
    logic [1:0]  dhost_ff, nxt_dhost;
    logic [23:0] blink_ff, nxt_blink;
    logic        init_go;

    // bus initialize and any init_and_poll write both restart; the written value only selects a diagnostic start
    assign init_go = bus_init | ip_wr;

    always_comb begin
        nxt_st     = st_ff;
        nxt_step   = step_ff;
        nxt_sa_rd  = sa_rd_ff;
        nxt_sa_wr  = sa_wr_ff;
        nxt_prm_ok = prm_ok_ff;
        nxt_poll   = 1'b0;
        nxt_diag   = 1'b0;
        nxt_dhost  = dhost_ff;
        nxt_blink  = blink_ff + 24'h000001;
        for (int i = 0; i < 4; i++) nxt_prm[i] = prm_ff[i];
        if (sa_wr) nxt_sa_wr = sa_wdata;
        if (init_go) begin
            nxt_st     = in_step;
            nxt_step   = 3'h0;
            nxt_prm_ok = 1'b0;
            nxt_sa_rd  = step_base;
            if (ip_wr) begin
                // diagnostic start words
                case (ip_wdata)
                    init_word_mini: begin
                        nxt_diag  = 1'b1;
                        nxt_dhost = 2'h0;
                    end
                    init_word_micro: begin
                        nxt_diag  = 1'b1;
                        nxt_dhost = 2'h1;
                    end
                    init_word_board: begin
                        nxt_diag  = 1'b1;
                        nxt_dhost = 2'h2;
                    end
                    default: ;
                endcase
            end
        end else begin
            case (st_ff)
                in_step: begin
                    if (flt_any) begin
                        nxt_st    = in_fatal;
                        nxt_sa_rd = flt_code;
                    end else if (sa_wr) begin
                        nxt_prm[step_ff[1:0]] = sa_wdata;
                        // echo the low byte of the word with the next step marker
                        nxt_sa_rd = (step_base << (step_ff + 3'h1)) | {8'h00, sa_wdata[7:0]};
                        nxt_step  = step_ff + 3'h1;
                        if (step_ff + 3'h1 == step_last) begin
                            nxt_st     = in_test;
                            nxt_prm_ok = 1'b1;
                        end
                    end
                end
                in_test: begin
                    if (flt_any) begin
                        nxt_st    = in_fatal;
                        nxt_sa_rd = flt_code;
                    end else if (test_done) begin
                        nxt_st    = in_run;
                        nxt_sa_rd = sa_idle_reset;
                    end
                end
                in_run: begin
                    if (flt_any) begin
                        nxt_st    = in_fatal;
                        nxt_sa_rd = flt_code;
                    end
                    if (ip_rd) nxt_poll = 1'b1;
                end
                in_fatal: begin
                    // code held; only a new init leaves this state
                    nxt_sa_rd = sa_rd_ff;
                end
                default: nxt_st = in_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff     <= in_idle;
            step_ff   <= 3'h0;
            sa_rd_ff  <= sa_idle_reset;
            sa_wr_ff  <= sa_idle_reset;
            prm_ok_ff <= 1'b0;
            poll_ff   <= 1'b0;
            diag_ff   <= 1'b0;
            dhost_ff  <= 2'h0;
            blink_ff  <= 24'h000000;
            for (int i = 0; i < 4; i++) prm_ff[i] <= 16'h0000;
        end else begin
            st_ff     <= nxt_st;
            step_ff   <= nxt_step;
            sa_rd_ff  <= nxt_sa_rd;
            sa_wr_ff  <= nxt_sa_wr;
            prm_ok_ff <= nxt_prm_ok;
            poll_ff   <= nxt_poll;
            diag_ff   <= nxt_diag;
            dhost_ff  <= nxt_dhost;
            blink_ff  <= nxt_blink;
            for (int i = 0; i < 4; i++) prm_ff[i] <= nxt_prm[i];
        end
    end

    // ----
    // command completion
    // ----
    // ecc itself lives in the disc data path; this slot only counts retries
    hpe_cmd_exec u_exec (
        .core_clk   (core_clk),
        .rst        (rst),
        .req        (cmd_req),
        .unit_wp    (unit_wp),
        .abort_req  (abort_req),
        .evt        (xfer_evt),
        .busy       (cmd_busy),
        .retry      (ecc_retry),
        .zero_fill  (erase_zero_fill),
        .unit_state (unit_state),
        .cpl        (cmd_cpl)
    );

    // ----
    // outputs
    // ----
    assign sa_rdata    = sa_rd_ff;
    assign init_pulse  = init_go;
    assign poll_pulse  = poll_ff;
    assign diag_start  = diag_ff;
    assign diag_host   = dhost_ff;
    assign param_valid = prm_ok_ff;
    assign running     = (st_ff == in_run);
    assign fatal_led   = (st_ff == in_fatal) & blink_ff[23];
    always_comb begin
        for (int i = 0; i < 4; i++) host_param[i] = prm_ff[i];
    end
endmodule // hpe_host_port

// [hpe_host_port_properties.sv]
// checker for the host register port and command completion
// assumes it is bound to hpe_host_port and sees only its ports
`timescale 1ns/1ps
module hpe_port_checker
    import hpe_pkg::*;
(
    // clock and reset
    input wire logic                core_clk,
    input wire logic                rst,
    // register side
    input wire logic                bus_init,
    input wire logic                ip_rd,
    input wire logic                ip_wr,
    input wire logic [15:0]         ip_wdata,
    input wire logic                test_done,
    input wire logic [n_faults-1:0] fault,
    input wire logic [15:0]         sa_rdata,
    // command side
    input wire cmd_req_t            cmd_req,
    input wire logic                unit_wp,
    input wire cmd_cpl_t            cmd_cpl,
    input wire logic                cmd_busy,
    // controller side
    input wire logic                init_pulse,
    input wire logic                poll_pulse,
    input wire logic                diag_start,
    input wire logic [1:0]          diag_host,
    input wire logic                running
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----
    // init and poll
    // ----
    a_wr_inits: assert property (ip_wr |-> init_pulse)
        else $error("write did not start init");
    a_step_first: assert property ((ip_wr || bus_init) |=> sa_rdata == step_base)
        else $error("no first step response");
    a_poll_run: assert property (ip_rd && running |=> poll_pulse)
        else $error("read while running did not poll");
    a_poll_idle: assert property (!(ip_rd && running) |=> !poll_pulse)
        else $error("poll without a running read");
    a_diag_mini: assert property (ip_wr && ip_wdata == init_word_mini |=> diag_start && diag_host == 2'h0)
        else $error("diagnostic word not decoded");
    // ----
    // fatal reporting and write protect refusal; step state shows as the first step value
    // ----
    a_code_ram: assert property (sa_rdata == step_base && fault[0] && !ip_wr && !bus_init
        |=> sa_rdata == fatal_ram)
        else $error("ram fault code wrong");
    a_code_parity: assert property (sa_rdata == step_base && fault == 11'h400 && !ip_wr && !bus_init
        |=> sa_rdata == fatal_parity)
        else $error("parity fault code wrong");
    a_fatal_hold: assert property (sa_rdata[15:8] inside {[8'hab:8'hb6]} && sa_rdata[7:0] == 8'h0b
        && !ip_wr && !bus_init && !test_done |=> $stable(sa_rdata))
        else $error("fatal code lost");
    a_wp_refuse: assert property (cmd_req.valid && !cmd_busy && cmd_req.op == op_write && unit_wp
        |=> cmd_cpl.valid && cmd_cpl.status == st_write_prot)
        else $error("protected write not refused");
    // main scenarios reached
    c_poll: cover property (ip_rd && running);
    c_fatal: cover property (sa_rdata == fatal_parity);
    c_wp: cover property (cmd_cpl.valid && cmd_cpl.status == st_write_prot);
endmodule // hpe_port_checker

bind hpe_host_port hpe_port_checker u_chk (.core_clk, .rst, .bus_init, .ip_rd, .ip_wr,
    .ip_wdata, .test_done, .fault, .sa_rdata, .cmd_req, .unit_wp, .cmd_cpl, .cmd_busy,
    .init_pulse, .poll_pulse, .diag_start, .diag_host, .running);

// [host_bfm.sv]
// host processor model issuing one-cycle register strobes
// assumes the bench calls its tasks; strobes change just after core_clk
`timescale 1ns/1ps
module host_bfm (
    // clock
    input wire logic    core_clk,
    // register strobes
    output logic        bus_init,
    output logic        ip_rd,
    output logic        ip_wr,
    output logic [15:0] ip_wdata,
    output logic        sa_rd,
    output logic        sa_wr,
    output logic [15:0] sa_wdata
);
    // quiet bus at time zero
    initial begin
        {bus_init, ip_rd, ip_wr, sa_rd, sa_wr, ip_wdata, sa_wdata} = '0;
    end
    // data is turned over after release so stale values never match
    task automatic ip_write(input logic [15:0] w);
        @(posedge core_clk);
        ip_wr <= 1'b1;
        ip_wdata <= w;
        @(posedge core_clk);
        ip_wr <= 1'b0;
        ip_wdata <= ~w;
    endtask
    // parameter word during the step phase
    task automatic sa_write(input logic [15:0] w);
        @(posedge core_clk);
        sa_wr <= 1'b1;
        sa_wdata <= w;
        @(posedge core_clk);
        sa_wr <= 1'b0;
        sa_wdata <= ~w;
    endtask
    // read after queuing a command
    task automatic ip_read();
        @(posedge core_clk);
        ip_rd <= 1'b1;
        @(posedge core_clk);
        ip_rd <= 1'b0;
    endtask
    // bus initialize pulse
    task automatic bus_reset();
        @(posedge core_clk);
        bus_init <= 1'b1;
        @(posedge core_clk);
        bus_init <= 1'b0;
    endtask
endmodule // host_bfm

// [tb_top.sv]
// self-checking bench for the host port, init steps, faults and commands
// assumes host_bfm drives the register strobes; the abort timeout outlasts the run
`timescale 1ns/1ps
module tb_top;
    import hpe_pkg::*;
    localparam logic [15:0] codes [0:10] = '{fatal_ram, fatal_rom, fatal_cache,
        fatal_unlock, fatal_get_msg, fatal_clr_rings, fatal_free_buf, fatal_q_unfork,
        fatal_q_wait, fatal_q_pause, fatal_parity};
    localparam logic [15:0] words [0:2] = '{init_word_mini, init_word_micro, init_word_board};
    logic                core_clk = 1'b0;
    logic                rst = 1'b1;
    logic                test_done = 1'b0;
    logic                unit_wp = 1'b0, abort_req = 1'b0;
    logic [n_faults-1:0] fault = '0;
    cmd_req_t            cmd_req = '0;
    xfer_evt_t           xfer_evt = '0;
    logic                bus_init, ip_rd, ip_wr, sa_rd, sa_wr;
    logic [15:0]         ip_wdata, sa_wdata, sa_rdata;
    logic [15:0]         host_param [0:3];
    cmd_cpl_t            cmd_cpl, last;
    logic                cmd_busy, ecc_retry, erase_zero_fill, init_pulse, poll_pulse;
    logic                diag_start, param_valid, running, fatal_led;
    logic [1:0]          diag_host;
    unit_state_t         unit_state;
    logic [7:0]          tg = 8'h00;
    logic [15:0]         q [$];
    int                  num_errors = 0, n_checks = 0, n_cpl = 0, n_retry = 0;

    host_bfm bfm (.core_clk, .bus_init, .ip_rd, .ip_wr, .ip_wdata, .sa_rd, .sa_wr, .sa_wdata);
    hpe_host_port dut (.core_clk, .rst, .bus_init, .ip_rd, .ip_wr, .ip_wdata, .sa_rd, .sa_wr,
        .sa_wdata, .sa_rdata, .test_done, .fault, .cmd_req, .unit_wp, .abort_req,
        .xfer_evt, .cmd_cpl, .cmd_busy, .ecc_retry, .erase_zero_fill, .unit_state,
        .init_pulse, .poll_pulse, .diag_start, .diag_host, .host_param, .param_valid,
        .running, .fatal_led);

    // ----
    // clock, monitor and checking
    // ----
    always #4 core_clk = ~core_clk;
    // completions and retries as the status model sees them
    always @(posedge core_clk) begin
        if (cmd_cpl.valid === 1'b1) begin
            last <= cmd_cpl;
            n_cpl <= n_cpl + 1;
        end
        if (ecc_retry === 1'b1) n_retry <= n_retry + 1;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // full init: four words, each echoed as a step response
    task automatic do_init();
        logic [15:0] w;
        q.delete();
        bfm.ip_write(16'($urandom));
        #1;
        chk("step_first", sa_rdata, step_base);
        for (int n = 0; n < 4; n++) begin
            w = 16'($urandom);
            q.push_back(w);
            bfm.sa_write(w);
            #1;
            chk("step_resp", sa_rdata, (step_base << (n + 1)) | {8'h00, w[7:0]});
            chk("host_param", host_param[n], q[n]);
        end
        chk("param_valid", param_valid, 1'b1);
        @(posedge core_clk);
        test_done <= 1'b1;
        @(posedge core_clk);
        test_done <= 1'b0;
        #1;
        chk("running", running, 1'b1);
        chk("sa_run", sa_rdata, sa_idle_reset);
    endtask
    // one command; events repeated n times, then the completion compared
    task automatic cmd(input opcode_t op, input logic wp, input xfer_evt_t e, input int n,
                       input cmd_status_t st);
        int c0;
        c0 = n_cpl;
        tg = tg + 8'h01;
        @(posedge core_clk);
        cmd_req <= '{1'b1, op, tg};
        unit_wp <= wp;
        @(posedge core_clk);
        cmd_req <= '0;
        #1;
        if (op == op_erase && !wp) chk("zero_fill", erase_zero_fill, 1'b1);
        repeat (n) begin
            @(posedge core_clk);
            xfer_evt <= e;
            @(posedge core_clk);
            xfer_evt <= '0;
        end
        repeat (30) if (n_cpl == c0) @(posedge core_clk);
        #1;
        chk("cpl_status", 16'(last.status), 16'(st));
        chk("cpl_tag", 16'(last.tag), 16'(tg));
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        int r0;
        void'($urandom(32'hf2af));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("sa_reset", sa_rdata, sa_idle_reset);
        bfm.ip_read();
        #1;
        chk("poll_idle", poll_pulse, 1'b0);
        do_init();
        bfm.ip_read();
        #1;
        chk("poll_run", poll_pulse, 1'b1);
        bfm.sa_write(~q[0]);
        #1;
        chk("sa_split", sa_rdata, sa_idle_reset);
        chk("param_keep", host_param[0], q[0]);
        // events: done 20, data_err 10, compare_miss 04, bus_fault 02, internal 01
        cmd(op_write, 1'b1, 6'h00, 0, st_write_prot);
        cmd(op_erase, 1'b1, 6'h00, 0, st_write_prot);
        cmd(op_erase, 1'b0, 6'h20, 1, st_success);
        cmd(op_compare, 1'b0, 6'h04, 1, st_compare_err);
        cmd(op_read, 1'b0, 6'h02, 1, st_host_buf_err);
        cmd(op_write, 1'b0, 6'h01, 1, st_ctrl_err);
        cmd(op_read, 1'b0, 6'h20, 1, st_success);
        // abort held over a read that still ends on its own event
        @(posedge core_clk);
        abort_req <= 1'b1;
        cmd(op_read, 1'b0, 6'h20, 1, st_success);
        @(posedge core_clk);
        abort_req <= 1'b0;
        r0 = n_retry;
        cmd(op_read, 1'b0, 6'h10, 11, st_data_err);
        chk("retries", 16'(n_retry - r0), 16'h000a);
        cmd(op_online, 1'b0, 6'h20, 1, st_success);
        repeat (2) begin
            cmd(op_available, 1'b0, 6'h20, 1, st_success);
            chk("unit_avail", 16'(unit_state), 16'(unit_available));
        end
        // fault while running latches its code
        @(posedge core_clk);
        fault <= 11'h010;
        @(posedge core_clk);
        fault <= '0;
        #1;
        chk("run_fatal", sa_rdata, fatal_get_msg);
        // every fault source during the step phase, held afterwards
        for (int i = 0; i < n_faults; i++) begin
            bfm.ip_write(16'(i));
            #1;
            chk("new_init", sa_rdata, step_base);
            @(posedge core_clk);
            fault <= 11'(1 << i);
            @(posedge core_clk);
            fault <= '0;
            repeat (3) @(posedge core_clk);
            #1;
            chk("fatal_code", sa_rdata, codes[i]);
        end
        bfm.bus_reset();
        #1;
        chk("bus_init", sa_rdata, step_base);
        chk("led_off", fatal_led, 1'b0);
        for (int j = 0; j < 3; j++) begin
            bfm.ip_write(words[j]);
            #1;
            chk("diag_start", diag_start, 1'b1);
            chk("diag_host", 16'(diag_host), 16'(j));
        end
        give_verdict();
    end
    // watchdog well past the expected few hundred cycles
    initial begin
        #(8 * 20000);
        num_errors++;
        give_verdict();
    end
endmodule // tb_top
